//--- bench/ppog_timer_model.sv
// Partner model: timer unit event pulses and shared pin ownership.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module ppog_timer_model (
    // Clock
    input wire logic ref_clk,
    // Timer events and pin owners
    output logic [3:0] cmp_a,
    output logic [3:0] cmp_b,
    output logic [3:0] cap_a,
    output logic [3:0] a_is_capture,
    output logic [7:0] pin_owned_elsewhere
);
    // Quiet timer, register A compares, all pins free
    initial
    begin
        cmp_a = 4'h0;
        cmp_b = 4'h0;
        cap_a = 4'h0;
        a_is_capture = 4'h0;
        pin_owned_elsewhere = 8'h00;
    end

    // One-cycle event after gap idle cycles; kind 0 match A, 1 match B, 2 capture
    task automatic pulse(input int kind, input int ch, input int gap);
        repeat (gap + 1) @(posedge ref_clk);
        case (kind)
            0: cmp_a[ch] <= 1'b1;
            1: cmp_b[ch] <= 1'b1;
            default: cap_a[ch] <= 1'b1;
        endcase
        @(posedge ref_clk);
        cmp_a <= 4'h0;
        cmp_b <= 4'h0;
        cap_a <= 4'h0;
    endtask : pulse

    // Changed only between events, never beside a pulse
    task automatic set_lines(input logic [3:0] cap, input logic [7:0] own);
        @(posedge ref_clk);
        a_is_capture <= cap;
        pin_owned_elsewhere <= own;
    endtask : set_lines
endmodule : ppog_timer_model

//--- bench/pulse_pattern_output_groups_tb.sv
// Self-checking bench for the pulse pattern output groups block.
// Assumes the timer partner model and fixed latencies of the register port.
`timescale 1ns/1ps
module pulse_pattern_output_groups_tb;
    import ppog_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] cmp_a, cmp_b, cap_a, a_is_capture;
    logic [7:0] owned, pins_o, pins_oe;
    int num_errors = 0;
    int n_compared = 0;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    ppog_top i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_a(cmp_a), .cmp_b(cmp_b), .cap_a(cap_a), .a_is_capture(a_is_capture),
        .pin_owned_elsewhere(owned), .pattern_pins_o(pins_o), .pattern_pins_oe(pins_oe));
    ppog_timer_model i_tmr (.ref_clk(ref_clk), .cmp_a(cmp_a), .cmp_b(cmp_b),
        .cap_a(cap_a), .a_is_capture(a_is_capture), .pin_owned_elsewhere(owned));

    // Shared comparison
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Register write, one strobe cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Register read; data is looked at only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rdchk

    // Pins after the registered enable has caught up
    task automatic chk_pins(input logic [7:0] exp_o, input logic [7:0] exp_oe);
        repeat (2) @(posedge ref_clk);
        #1 check(pins_o, exp_o);
        check(pins_oe, exp_oe);
    endtask : chk_pins

    task automatic s_reset();
        rdchk(ADDR_TRIG, 8'h00);
        wr(ADDR_DDR, 8'hFF);
        wr(ADDR_STOP, 8'h00);
        rdchk(ADDR_DDR, 8'h00);
        rdchk(ADDR_TRIG, TRIG_RST);
        rdchk(ADDR_MODE, {4'h0, MODE_RST});
        rdchk(4'h9, UNMAPPED_RD);
    endtask : s_reset

    task automatic s_initial();
        wr(ADDR_POD, 8'h5A);
        wr(ADDR_DDR, 8'h0F);
        chk_pins(8'h5A, 8'h00);
        wr(ADDR_NEXT_PATTERN_ENABLE, 8'h3C);
        chk_pins(8'h5A, 8'h0C);
        wr(ADDR_POD, 8'hA5);
        rdchk(ADDR_POD, 8'h99);
        wr(ADDR_DDR, 8'hFF);
        wr(ADDR_NEXT_PATTERN_ENABLE, 8'hFF);
    endtask : s_initial

    // Every channel code; wrong channel and match B must not transfer
    task automatic s_normal();
        logic [7:0] d;
        logic [7:0] prev;
        prev = 8'h99;
        for (int ch = 0; ch < 4; ch++)
        begin
            d = 8'(8'h11 * (ch + 1));
            wr(ADDR_TRIG, {2'(ch), 2'(ch), 4'hF});
            wr(ADDR_NDR, d);
            i_tmr.pulse(0, (ch + 1) % 4, 0);
            i_tmr.pulse(1, ch, 1);
            chk_pins(prev, 8'hFF);
            i_tmr.pulse(0, ch, 0);
            chk_pins(d, 8'hFF);
            prev = d;
        end
    endtask : s_normal

    task automatic s_nonoverlap();
        wr(ADDR_MODE, 8'h0F);
        wr(ADDR_NDR, 8'h95);
        i_tmr.pulse(0, 3, 2);
        chk_pins(8'h95, 8'hFF);
        wr(ADDR_NDR, 8'h65);
        i_tmr.pulse(1, 3, 0);
        chk_pins(8'h05, 8'hFF);
        i_tmr.pulse(0, 3, 0);
        chk_pins(8'h65, 8'hFF);
    endtask : s_nonoverlap

    task automatic s_invert();
        wr(ADDR_MODE, 8'h00);
        chk_pins(8'h9A, 8'hFF);
        wr(ADDR_MODE, 8'h08);
        chk_pins(8'h6A, 8'hFF);
        wr(ADDR_MODE, 8'h0C);
    endtask : s_invert

    // Capture replaces match A; foreign owners mask drive only
    task automatic s_capture_owned();
        i_tmr.set_lines(4'h8, 8'h00);
        wr(ADDR_NDR, 8'h3C);
        i_tmr.pulse(0, 3, 0);
        chk_pins(8'h65, 8'hFF);
        i_tmr.pulse(2, 3, 0);
        chk_pins(8'h3C, 8'hFF);
        i_tmr.set_lines(4'h0, 8'hF0);
        wr(ADDR_NDR, 8'hC3);
        i_tmr.pulse(0, 3, 0);
        chk_pins(8'hC3, 8'h0F);
        i_tmr.set_lines(4'h0, 8'h00);
    endtask : s_capture_owned

    // Split halves with group 3 on channel 3 and group 2 on channel 1
    task automatic s_split();
        wr(ADDR_TRIG, 8'hDF);
        wr(ADDR_NDR_G3, 8'hA0);
        wr(ADDR_NDR_G2, 8'h05);
        rdchk(ADDR_NDR_G3, 8'hAF);
        rdchk(ADDR_NDR_G2, 8'hF5);
        rdchk(ADDR_NDR, 8'h00);
        i_tmr.pulse(0, 3, 0);
        chk_pins(8'hA3, 8'hFF);
        i_tmr.pulse(0, 1, 0);
        chk_pins(8'hA5, 8'hFF);
    endtask : s_split

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        s_reset();
        s_initial();
        s_normal();
        s_nonoverlap();
        s_invert();
        s_capture_owned();
        s_split();
        tally_and_finish();
    end

    // Hang guard; the whole run needs far fewer cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        tally_and_finish();
    end
endmodule : pulse_pattern_output_groups_tb

//--- core/ppog_group_xfer.sv
// One four-bit output group: trigger pick and next-data transfer.
// Assumes timer event pulses are one cycle long on the same clock.
`timescale 1ns/1ps
module ppog_group_xfer
    import ppog_pkg::*;
(
    // Group settings
    input wire logic [1:0] trig_sel,
    input wire logic non_overlap,
    input wire logic run,
    // Timer events per channel
    input wire logic [3:0] cmp_a,
    input wire logic [3:0] cmp_b,
    input wire logic [3:0] cap_a,
    input wire logic [3:0] a_is_capture,
    // Group data
    input wire logic [3:0] next_bits,
    input wire logic [3:0] enable_bits,
    input wire logic [3:0] out_bits,
    output logic [3:0] out_next,
    output logic fire_a,
    output logic fire_b
);
    // Channel picked by the two-bit select code
    function automatic logic pick(input logic [1:0] sel, input logic [3:0] vec);
        pick = vec[sel];
    endfunction : pick

    logic ev_a;
    logic ev_b;
    logic [3:0] copy_all;
    logic [3:0] copy_zero;

    // Capture replaces compare match A when register A captures
    assign ev_a = pick(trig_sel, a_is_capture) ? pick(trig_sel, cap_a)
                                               : pick(trig_sel, cmp_a);
    assign ev_b = pick(trig_sel, cmp_b);
    assign fire_a = run & ev_a;
    assign fire_b = run & non_overlap & ev_b;

    // Only enabled bits move, so software-owned bits are never clobbered
    assign copy_all = (out_bits & ~enable_bits) | (next_bits & enable_bits);
    assign copy_zero = out_bits & ~(enable_bits & ~next_bits);

    // A wins over B when both land together, it copies everything
    assign out_next = fire_a ? copy_all : (fire_b ? copy_zero : out_bits);
endmodule : ppog_group_xfer

//--- core/ppog_pkg.sv
// Package for the pulse pattern output groups block.
// Assumes an 8-bit register port and timer events on the same clock.
package ppog_pkg;
    // Register port shape
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned NUM_GRP = 2;
    localparam int unsigned GRP_W = 4;

    // Register offsets
    localparam logic [3:0] ADDR_TRIG = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_NEXT_PATTERN_ENABLE = 4'h2;
    localparam logic [3:0] ADDR_POD = 4'h3;
    localparam logic [3:0] ADDR_NDR = 4'h4;
    localparam logic [3:0] ADDR_NDR_G3 = 4'h5;
    localparam logic [3:0] ADDR_NDR_G2 = 4'h6;
    localparam logic [3:0] ADDR_DDR = 4'h7;
    localparam logic [3:0] ADDR_STOP = 4'h8;

    // Reset values
    localparam logic [7:0] TRIG_RST = 8'hFF;
    localparam logic [3:0] MODE_RST = 4'hC;
    localparam logic [7:0] NEXT_PATTERN_ENABLE_RST = 8'h00;
    localparam logic [7:0] POD_RST = 8'h00;
    localparam logic [7:0] NDR_RST = 8'h00;
    localparam logic [7:0] DDR_RST = 8'h00;
    localparam logic STOP_RST = 1'b1;

    // Field positions: group 2 first, group 3 follows
    localparam int unsigned TRIG_G2_LSB = 4;
    localparam int unsigned MODE_NOV_G2 = 0;
    localparam int unsigned MODE_INV_G2 = 2;
    localparam int unsigned STOP_BIT = 0;

    // Fill for the unused half of a split next-data address
    localparam logic [3:0] SPLIT_FILL = 4'hF;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage : ppog_pkg

//--- core/ppog_top.sv
// Top of the pulse pattern output groups block: registers, groups, pins.
// Assumes a plain register port and timer events on ref_clk.
// Overview of operation
// - Two-bit code picks timer channel 0..3
// - Pin driven only when direction and enable set
// - Before triggers, pins show software output data
// - Selected trigger copies next data to output
// - Inverted mode: one drives low, zero high
// - Inversion bit at zero selects inverted output
// - Non-overlap bit at one uses matches A,B
// - Non-overlap: match A copies every bit
// - Non-overlap: match B copies only zero bits
// - Capture on register A acts as trigger
// - Reset leaves module stopped, registers locked
// - Foreign pin owner blocks drive, transfers continue
// - Enabled output bits ignore register writes
// - Split next-data halves, unused bits read one
`timescale 1ns/1ps
module ppog_top
    import ppog_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Timer unit events, one bit per channel
    input wire logic [3:0] cmp_a,
    input wire logic [3:0] cmp_b,
    input wire logic [3:0] cap_a,
    input wire logic [3:0] a_is_capture,
    // Shared pin ownership by other peripherals
    input wire logic [7:0] pin_owned_elsewhere,
    // Pattern pins, bit 7 is output 15
    output logic [7:0] pattern_pins_o,
    output logic [7:0] pattern_pins_oe
);
    // Address match, used for every register
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    logic [7:0] trig_q;
    logic [7:0] trig_d;
    logic [3:0] mode_q;
    logic [3:0] mode_d;
    logic [7:0] next_pattern_enable_q;
    logic [7:0] next_pattern_enable_d;
    logic [7:0] pod_q;
    logic [7:0] pod_d;
    logic [7:0] pod_base;
    logic [7:0] ndr_q;
    logic [7:0] ndr_d;
    logic [7:0] ddr_q;
    logic [7:0] ddr_d;
    logic stop_q;
    logic stop_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] pin_q;
    logic [7:0] oe_q;
    logic [7:0] oe_d;
    logic [7:0] inv_mask;
    logic [7:0] inv_mask_d;
    logic [1:0] fire_a;
    logic [1:0] fire_b;
    logic wr_ok;
    logic rd_ok;
    logic same_trig;
    logic ndr_hi_wr;
    logic ndr_lo_wr;
    logic [7:0] ndr_rd_val;

    // Accesses other than the stop bit are dead while stopped
    assign wr_ok = reg_wr & ~stop_q;
    assign rd_ok = reg_rd & ~stop_q;
    assign same_trig = (trig_q[7:6] == trig_q[5:4]);

    // Control register next values
    assign trig_d = (wr_ok & hit(reg_addr, ADDR_TRIG)) ? reg_wdata : trig_q;
    assign mode_d = (wr_ok & hit(reg_addr, ADDR_MODE)) ? reg_wdata[3:0] : mode_q;
    assign next_pattern_enable_d = (wr_ok & hit(reg_addr, ADDR_NEXT_PATTERN_ENABLE)) ? reg_wdata : next_pattern_enable_q;
    assign ddr_d = (wr_ok & hit(reg_addr, ADDR_DDR)) ? reg_wdata : ddr_q;
    assign stop_d = (reg_wr & hit(reg_addr, ADDR_STOP)) ? reg_wdata[STOP_BIT] : stop_q;

    // Next data: one address when triggers match, two when they differ
    assign ndr_hi_wr = wr_ok & ((hit(reg_addr, ADDR_NDR) & same_trig)
                     | (hit(reg_addr, ADDR_NDR_G3) & ~same_trig));
    assign ndr_lo_wr = wr_ok & ((hit(reg_addr, ADDR_NDR) & same_trig)
                     | (hit(reg_addr, ADDR_NDR_G2) & ~same_trig));
    assign ndr_d[7:4] = ndr_hi_wr ? reg_wdata[7:4] : ndr_q[7:4];
    assign ndr_d[3:0] = ndr_lo_wr ? reg_wdata[3:0] : ndr_q[3:0];

    // Output data write only reaches bits not under trigger control
    assign pod_base = (wr_ok & hit(reg_addr, ADDR_POD))
                    ? ((pod_q & next_pattern_enable_q) | (reg_wdata & ~next_pattern_enable_q)) : pod_q;

    // Checks on the register side and the pins; declared ahead of the
    // group loop so the checks inside it share the same clock and reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // Groups: index 0 is group 2 (low nibble), index 1 is group 3
    genvar g;
    generate
        for (g = 0; g < NUM_GRP; g++)
        begin : grp
            localparam int LO = GRP_W * g;
            ppog_group_xfer u_xfer (
                .trig_sel(trig_q[TRIG_G2_LSB + 2 * g +: 2]),
                .non_overlap(mode_q[MODE_NOV_G2 + g]),
                .run(~stop_q),
                .cmp_a(cmp_a),
                .cmp_b(cmp_b),
                .cap_a(cap_a),
                .a_is_capture(a_is_capture),
                .next_bits(ndr_q[LO +: 4]),
                .enable_bits(next_pattern_enable_q[LO +: 4]),
                .out_bits(pod_base[LO +: 4]),
                .out_next(pod_d[LO +: 4]),
                .fire_a(fire_a[g]),
                .fire_b(fire_b[g])
            );
            // Inversion bit low means complement on the pins
            assign inv_mask[LO +: 4] = {4{~mode_q[MODE_INV_G2 + g]}};
            assign inv_mask_d[LO +: 4] = {4{~mode_d[MODE_INV_G2 + g]}};

            // Match A moves every enabled bit
            xfer_a_a: assert property (fire_a[g] |=> (((pod_q[LO +: 4]
                ^ $past(ndr_q[LO +: 4])) & $past(next_pattern_enable_q[LO +: 4])) == 4'h0))
                else $error("match A transfer missed");
            // Match B clears zero bits and keeps one bits
            xfer_b_a: assert property ((fire_b[g] && !fire_a[g]) |=>
                (((pod_q[LO +: 4] & $past(next_pattern_enable_q[LO +: 4] & ~ndr_q[LO +: 4])) == 4'h0)
                && (((pod_q[LO +: 4] ^ $past(pod_q[LO +: 4]))
                & $past(next_pattern_enable_q[LO +: 4] & ndr_q[LO +: 4])) == 4'h0)))
                else $error("match B transfer wrong");
            // Enabled bits hold unless the group fires
            hold_bits_a: assert property ((!fire_a[g] && !fire_b[g]) |=>
                (((pod_q[LO +: 4] ^ $past(pod_q[LO +: 4]))
                & $past(next_pattern_enable_q[LO +: 4])) == 4'h0))
                else $error("enabled output bits changed without trigger");
            // Normal mode never fires on match B
            no_b_normal_a: assert property (!mode_q[MODE_NOV_G2 + g] |-> !fire_b[g])
                else $error("match B fired in normal mode");
        end
    endgenerate

    // Read mux; halves of a split address fill their unused bits with ones
    assign ndr_rd_val = hit(reg_addr, ADDR_NDR) ? (same_trig ? ndr_q : UNMAPPED_RD)
        : hit(reg_addr, ADDR_NDR_G3) ? (same_trig ? UNMAPPED_RD
        : {ndr_q[7:4], SPLIT_FILL})
        : (same_trig ? UNMAPPED_RD : {SPLIT_FILL, ndr_q[3:0]});
    assign rdata_d = hit(reg_addr, ADDR_STOP) ? (reg_rd ? {7'h00, stop_q} : UNMAPPED_RD)
        : !rd_ok ? UNMAPPED_RD
        : hit(reg_addr, ADDR_TRIG) ? trig_q
        : hit(reg_addr, ADDR_MODE) ? {4'h0, mode_q}
        : hit(reg_addr, ADDR_NEXT_PATTERN_ENABLE) ? next_pattern_enable_q
        : hit(reg_addr, ADDR_POD) ? pod_q
        : hit(reg_addr, ADDR_DDR) ? ddr_q
        : (hit(reg_addr, ADDR_NDR) | hit(reg_addr, ADDR_NDR_G3)
        | hit(reg_addr, ADDR_NDR_G2)) ? ndr_rd_val
        : UNMAPPED_RD;

    // Pin drive needs direction, enable, free pin and a running block
    assign oe_d = ddr_d & next_pattern_enable_d & ~pin_owned_elsewhere & {8{~stop_d}};

    // Register state
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            trig_q <= TRIG_RST;
            mode_q <= MODE_RST;
            next_pattern_enable_q <= NEXT_PATTERN_ENABLE_RST;
            ddr_q <= DDR_RST;
            ndr_q <= NDR_RST;
            stop_q <= STOP_RST;
        end
        else
        begin
            trig_q <= trig_d;
            mode_q <= mode_d;
            next_pattern_enable_q <= next_pattern_enable_d;
            ddr_q <= ddr_d;
            ndr_q <= ndr_d;
            stop_q <= stop_d;
        end
    end

    // Output data, read data and pins; pins track the output data register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pod_q <= POD_RST;
            rdata_q <= UNMAPPED_RD;
            pin_q <= POD_RST;
            oe_q <= 8'h00;
        end
        else
        begin
            pod_q <= pod_d;
            rdata_q <= rdata_d;
            pin_q <= pod_d ^ inv_mask_d;
            oe_q <= oe_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign pattern_pins_o = pin_q;
    assign pattern_pins_oe = oe_q;

    // Stopped block drives nothing and keeps its data
    stop_quiet_a: assert property (stop_q |-> (pattern_pins_oe == 8'h00))
        else $error("pins driven while stopped");
    stop_hold_a: assert property (stop_q |=> $stable(pod_q) && $stable(ndr_q))
        else $error("state changed while stopped");
    // Drive follows direction, enable and ownership
    pin_drive_a: assert property (pattern_pins_oe == (ddr_q & next_pattern_enable_q
        & ~$past(pin_owned_elsewhere) & {8{~stop_q}}))
        else $error("pin enable mismatch");
    // Pin level is the output data, complemented per group when inverted
    pin_level_a: assert property (pattern_pins_o == (pod_q ^ inv_mask))
        else $error("pin level mismatch");
    // Software-set initial value reaches the pins one cycle later
    init_value_a: assert property ((wr_ok && hit(reg_addr, ADDR_POD)
        && (fire_a == 2'b00) && (fire_b == 2'b00)) |=>
        (((pattern_pins_o ^ inv_mask ^ $past(reg_wdata)) & ~$past(next_pattern_enable_q)) == 8'h00))
        else $error("initial output value not shown");
    // Group 3 half reads carry ones in the lower nibble
    split_read_a: assert property ((rd_ok && !same_trig && hit(reg_addr, ADDR_NDR_G3))
        |=> (reg_rdata[3:0] == SPLIT_FILL))
        else $error("split half fill not ones");
    // Read data stands only in the cycle after the strobe
    read_idle_a: assert property (!reg_rd |=> (reg_rdata == 8'h00))
        else $error("read data outside its cycle");
    // Capture on register A fires group 3 on the channel group 3 selects
    capture_fire_a: assert property ((!stop_q && a_is_capture[trig_q[7:6]]
        && cap_a[trig_q[7:6]]) |-> fire_a[1])
        else $error("capture did not trigger group 3");
    // Triggers are dead while the block is stopped
    stop_no_fire_a: assert property (stop_q |-> ((fire_a == 2'b00) && (fire_b == 2'b00)))
        else $error("trigger taken while stopped");
    // Reads while stopped return nothing but the stop bit
    stop_read_a: assert property ((reg_rd && stop_q && !hit(reg_addr, ADDR_STOP))
        |=> (reg_rdata == UNMAPPED_RD))
        else $error("register read while stopped");
    // Shared next-data address is closed while the triggers differ
    split_wr_a: assert property ((reg_wr && !same_trig && hit(reg_addr, ADDR_NDR))
        |=> $stable(ndr_q))
        else $error("shared next-data address written while split");
    // Group 2 half reads carry ones in the upper nibble
    split_read_lo_a: assert property ((rd_ok && !same_trig && hit(reg_addr, ADDR_NDR_G2))
        |=> (reg_rdata[7:4] == SPLIT_FILL))
        else $error("split low half fill not ones");
    // A pin owned elsewhere is never driven, whatever the settings
    owned_quiet_a: assert property ((pattern_pins_oe & $past(pin_owned_elsewhere)) == 8'h00)
        else $error("pin driven while owned elsewhere");
    // Group 3 ignores events on channels it does not select
    unselected_quiet_a: assert property (((cmp_a[trig_q[7:6]] == 1'b0)
        && (cap_a[trig_q[7:6]] == 1'b0)) |-> !fire_a[1])
        else $error("group 3 fired without its event");
    // Mode register upper bits always read as zero
    mode_read_a: assert property ((rd_ok && hit(reg_addr, ADDR_MODE))
        |=> (reg_rdata[7:4] == 4'h0))
        else $error("mode upper bits not zero");

    // Main scenarios
    cov_normal_c: cover property (fire_a[0] && !mode_q[MODE_NOV_G2]);
    cov_nov_b_c: cover property (fire_b[1] ##[1:50] fire_a[1]);
    cov_capture_c: cover property (fire_a[1] && a_is_capture[trig_q[7:6]]);
    cov_split_c: cover property (rd_ok && !same_trig && hit(reg_addr, ADDR_NDR_G2));
    // Transfer while another peripheral holds some of the pins
    cov_owned_c: cover property ((fire_a != 2'b00) && (pin_owned_elsewhere != 8'h00));
endmodule : ppog_top
